// file: pin_routing_defines.vh
// Purpose: constants for the port pin function routing block
// Assumes: included by bare name
// Notes:   host codes index the per-host vectors; a pin's select field holds host code plus one
`ifndef PIN_ROUTING_DEFINES_VH
`define PIN_ROUTING_DEFINES_VH

`define PIN_COUNT        20
`define HOST_COUNT       7
`define SEL_WIDTH        3

// Host index within each per-host vector
`define HOST_CARD        0
`define HOST_ATA         1
`define HOST_MEDIA       2
`define HOST_SD          3
`define HOST_STICK       4
`define HOST_TIMER       5
`define HOST_SERIAL      6

// Select codes; code = host index + 1, zero keeps the pin general purpose
`define SEL_GPIO         3'h0

// Pin index within each pin vector
`define PIN_J0           0
`define PIN_J1           1
`define PIN_J2           2
`define PIN_M3           3
`define PIN_M4           4
`define PIN_Q0           5
`define PIN_Q3           8
`define PIN_Q4           9
`define PIN_Q5           10
`define PIN_Q6           11
`define PIN_Q7           12
`define PIN_S4           13
`define PIN_S5           14
`define PIN_S6           15
`define PIN_S7           16
`define PIN_T0           17
`define PIN_T1           18
`define PIN_U0           19

// Host availability masks, bit n = host index n
`define AVAIL_CARD_ATA_MEDIA   7'h07
`define AVAIL_SD_TIM_CARD_MED  7'h2D
`define AVAIL_TIM_ATA_CARD_MED 7'h27
`define AVAIL_TIM_CARD_MED     7'h25
`define AVAIL_SERIAL           7'h40
`define AVAIL_STICK_ATA_CARD   7'h13
`define AVAIL_NONE             7'h00

// Reset values
`define RST_PULLUP_E     1'h1
`define RST_X_MASK       1'h1
`define RST_ROM_ENABLE   1'h0

`endif

// file: pin_function_cell.v
// Purpose: one pin's function mux between hosts and general purpose
// Assumes: select code already stable for the cycle
// Notes:   a code for a host not wired to this pin falls back to general purpose
`timescale 1ns/10ps
`include "pin_routing_defines.vh"

module pin_function_cell #(
    parameter [`HOST_COUNT-1:0] AVAIL = `AVAIL_NONE
) (
    input  wire [`SEL_WIDTH-1:0]  sel_i,
    input  wire [`HOST_COUNT-1:0] host_out_i,
    input  wire [`HOST_COUNT-1:0] host_oe_i,
    input  wire                   gpio_data_i,
    input  wire                   gpio_dir_i,
    input  wire                   pin_in_i,
    output reg                    pin_out_o,
    output reg                    pin_oe_o,
    output reg  [`HOST_COUNT-1:0] host_in_o
);

    reg [`HOST_COUNT-1:0] routed;
    integer               h;

    always @* begin
        routed = {`HOST_COUNT{1'b0}};
        for (h = 0; h < `HOST_COUNT; h = h + 1) begin
            if (sel_i == h[`SEL_WIDTH-1:0] + 3'h1) begin
                routed[h] = AVAIL[h];
            end
        end
        if (|routed) begin
            pin_out_o = |(routed & host_out_i);
            pin_oe_o  = |(routed & host_oe_i);
        end else begin
            pin_out_o = gpio_data_i;
            pin_oe_o  = gpio_dir_i;
        end
        // Unrouted hosts see a steady zero, not the pin
        host_in_o = routed & {`HOST_COUNT{pin_in_i}};
    end

endmodule // pin_function_cell

// file: port_pin_function_routing.v
// Purpose: pin function routing and reset behaviour for ports E0, J, M, Q, S, T, U
// Assumes: pins synchronous to clk_i; peripherals drive per-host out/oe vectors
// Notes:   pad drive is out + oe; the pad ring resolves the wire level
//
// Notes on behaviour
// - Port E bit 0 always readable input
// - Port E bit 0 is active-low nonmaskable request
// - Reset sets mask; requests ignored until cleared
// - Request level sensitive; wired-OR sources allowed
// - Port E pull-up on in and after reset
// - Clearing pull-up enable bit disables pull-up
// - Expanded mode: J2 latched into ROM enable
// - Routed pins high-impedance inputs through reset
// - J2: card enable 2, ATA select 1, protect
// - J1: card enable 1, ATA select 0, CLE
// - J0: card/ATA write strobe or ALE
// - M4: SD data2, io16, timer3, media busy
// - M3: SD data1, timer2, input ack, chip enable
// - Q7/Q6: timer, card address, media data, SD clock on Q6 only
// - Q5/Q4: timer, SD command/DMA ack, address, data
// - Q3..Q0: read strobe/ATA address, card address, data
// - S7: stick data, ATA interrupt, card ready
// - S6: stick clock, ATA DMA request, write enable
// - S5/S4: serial transmit and receive, else GPIO
// - T1: timer1, SD data3, media write, card OE
// - T0: attribute select, timer0, SD data0, read enable
// - U0: card wait, ATA ready, card detect
`timescale 1ns/10ps
`include "pin_routing_defines.vh"

module port_pin_function_routing #(
    parameter PINS  = `PIN_COUNT,
    parameter HOSTS = `HOST_COUNT
) (
    input  wire                      clk_i,
    input  wire                      reset_n_i,
    // Port E bit 0 and nonmaskable request
    input  wire                      port_e_bit0_i,
    output reg                       port_e_bit0_o,
    output reg                       nonmaskable_irq_req_o,
    input  wire                      x_mask_clear_i,
    output reg                       x_mask_o,
    input  wire                      pullup_write_i,
    input  wire                      port_e_pullup_enable_i,
    output wire                      port_e_pullup_on_o,
    // ROM enable strap
    input  wire                      expanded_mode_i,
    output reg                       onchip_rom_enable_o,
    // Routing controls, one select field per pin
    input  wire [PINS*`SEL_WIDTH-1:0] func_sel_i,
    input  wire [PINS-1:0]           gpio_data_i,
    input  wire [PINS-1:0]           gpio_dir_i,
    output reg  [PINS-1:0]           gpio_in_o,
    // Pads
    input  wire [PINS-1:0]           pad_in_i,
    output reg  [PINS-1:0]           pad_out_o,
    output reg  [PINS-1:0]           pad_oe_o,
    // Peripheral side, one vector per host indexed by pin
    input  wire [PINS-1:0]           flash_card_host_out_i,
    input  wire [PINS-1:0]           flash_card_host_oe_i,
    output reg  [PINS-1:0]           flash_card_host_in_o,
    input  wire [PINS-1:0]           ata_host_out_i,
    input  wire [PINS-1:0]           ata_host_oe_i,
    output reg  [PINS-1:0]           ata_host_in_o,
    input  wire [PINS-1:0]           nand_media_host_out_i,
    input  wire [PINS-1:0]           nand_media_host_oe_i,
    output reg  [PINS-1:0]           nand_media_host_in_o,
    input  wire [PINS-1:0]           sd_host_out_i,
    input  wire [PINS-1:0]           sd_host_oe_i,
    output reg  [PINS-1:0]           sd_host_in_o,
    input  wire [PINS-1:0]           stick_card_host_out_i,
    input  wire [PINS-1:0]           stick_card_host_oe_i,
    output reg  [PINS-1:0]           stick_card_host_in_o,
    input  wire [PINS-1:0]           capture_timer_out_i,
    input  wire [PINS-1:0]           capture_timer_oe_i,
    output reg  [PINS-1:0]           capture_timer_in_o,
    input  wire [PINS-1:0]           async_serial_port_out_i,
    input  wire [PINS-1:0]           async_serial_port_oe_i,
    output reg  [PINS-1:0]           async_serial_port_in_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Which hosts reach which pin
    function [`HOST_COUNT-1:0] pin_avail;
        input integer idx;
        begin
            if (idx <= `PIN_J2)
                pin_avail = `AVAIL_CARD_ATA_MEDIA;
            else if (idx <= `PIN_M4)
                pin_avail = `AVAIL_SD_TIM_CARD_MED;
            else if (idx <= `PIN_Q3)
                pin_avail = `AVAIL_CARD_ATA_MEDIA;
            else if (idx == `PIN_Q4)
                pin_avail = `AVAIL_TIM_ATA_CARD_MED;
            else if (idx <= `PIN_Q6)
                pin_avail = `AVAIL_SD_TIM_CARD_MED;
            else if (idx == `PIN_Q7)
                pin_avail = `AVAIL_TIM_CARD_MED;
            else if (idx <= `PIN_S5)
                pin_avail = `AVAIL_SERIAL;
            else if (idx <= `PIN_S7)
                pin_avail = `AVAIL_STICK_ATA_CARD;
            else if (idx <= `PIN_T1)
                pin_avail = `AVAIL_SD_TIM_CARD_MED;
            else if (idx == `PIN_U0)
                pin_avail = `AVAIL_CARD_ATA_MEDIA;
            else
                pin_avail = `AVAIL_NONE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin muxes
    wire [PINS-1:0]       next_pad_out;
    wire [PINS-1:0]       next_pad_oe;
    wire [PINS*HOSTS-1:0] next_host_in;

    genvar p;
    generate
        for (p = 0; p < PINS; p = p + 1) begin : g_pin
            wire [HOSTS-1:0] host_out;
            wire [HOSTS-1:0] host_oe;

            assign host_out = {async_serial_port_out_i[p], capture_timer_out_i[p],
                               stick_card_host_out_i[p], sd_host_out_i[p],
                               nand_media_host_out_i[p], ata_host_out_i[p],
                               flash_card_host_out_i[p]};
            assign host_oe  = {async_serial_port_oe_i[p], capture_timer_oe_i[p],
                               stick_card_host_oe_i[p], sd_host_oe_i[p],
                               nand_media_host_oe_i[p], ata_host_oe_i[p],
                               flash_card_host_oe_i[p]};

            pin_function_cell #(
                .AVAIL (pin_avail(p))
            ) u_cell (
                .sel_i       (func_sel_i[p*`SEL_WIDTH +: `SEL_WIDTH]),
                .host_out_i  (host_out),
                .host_oe_i   (host_oe),
                .gpio_data_i (gpio_data_i[p]),
                .gpio_dir_i  (gpio_dir_i[p]),
                .pin_in_i    (pad_in_i[p]),
                .pin_out_o   (next_pad_out[p]),
                .pin_oe_o    (next_pad_oe[p]),
                .host_in_o   (next_host_in[p*HOSTS +: HOSTS])
            );
        end
    endgenerate

    // Regroup the per-pin host inputs into per-host vectors
    reg [PINS-1:0] next_in_by_host [0:HOSTS-1];
    integer        i;
    integer        k;

    always @* begin
        for (k = 0; k < HOSTS; k = k + 1) begin
            for (i = 0; i < PINS; i = i + 1) begin
                next_in_by_host[k][i] = next_host_in[i*HOSTS + k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive and input capture
    // Output enables stay low through reset and the first edge after it
    reg drive_allowed;

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            drive_allowed          <= 1'b0;
            pad_out_o              <= {PINS{1'b0}};
            pad_oe_o               <= {PINS{1'b0}};
            gpio_in_o              <= {PINS{1'b0}};
            flash_card_host_in_o   <= {PINS{1'b0}};
            ata_host_in_o          <= {PINS{1'b0}};
            nand_media_host_in_o   <= {PINS{1'b0}};
            sd_host_in_o           <= {PINS{1'b0}};
            stick_card_host_in_o   <= {PINS{1'b0}};
            capture_timer_in_o     <= {PINS{1'b0}};
            async_serial_port_in_o <= {PINS{1'b0}};
        end else begin
            drive_allowed          <= 1'b1;
            pad_out_o              <= next_pad_out;
            pad_oe_o               <= next_pad_oe & {PINS{drive_allowed}};
            gpio_in_o              <= pad_in_i;
            flash_card_host_in_o   <= next_in_by_host[`HOST_CARD];
            ata_host_in_o          <= next_in_by_host[`HOST_ATA];
            nand_media_host_in_o   <= next_in_by_host[`HOST_MEDIA];
            sd_host_in_o           <= next_in_by_host[`HOST_SD];
            stick_card_host_in_o   <= next_in_by_host[`HOST_STICK];
            capture_timer_in_o     <= next_in_by_host[`HOST_TIMER];
            async_serial_port_in_o <= next_in_by_host[`HOST_SERIAL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port E bit 0 and the nonmaskable request
    reg pullup_enable;

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            port_e_bit0_o         <= 1'b1;
            x_mask_o              <= `RST_X_MASK;
            nonmaskable_irq_req_o <= 1'b0;
            pullup_enable         <= `RST_PULLUP_E;
        end else begin
            port_e_bit0_o <= port_e_bit0_i;
            // Mask can only be cleared; software cannot set it again
            if (x_mask_clear_i) begin
                x_mask_o <= 1'b0;
            end
            // Level, not edge: holds while any wired-OR source pulls low
            nonmaskable_irq_req_o <= ~port_e_bit0_i & ~x_mask_o;
            if (pullup_write_i) begin
                pullup_enable <= port_e_pullup_enable_i;
            end
        end
    end

    // Pull-up also held on while reset is low, before any clock edge
    assign port_e_pullup_on_o = ~reset_n_i | pullup_enable;

    ////////////////////////////////////////////////////////////////////////////
    // ROM enable strap, caught on the first edge after reset release
    reg reset_seen;

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            reset_seen          <= 1'b1;
            onchip_rom_enable_o <= `RST_ROM_ENABLE;
        end else begin
            reset_seen <= 1'b0;
            if (reset_seen && expanded_mode_i) begin
                onchip_rom_enable_o <= pad_in_i[`PIN_J2];
            end
        end
    end

endmodule // port_pin_function_routing

// file: pin_partner_model.sv
// Purpose: pads and external request sources around the routing block
// Assumes: pads settle between clock edges
// Notes:   an undriven pad shows the inverse of its last level
`timescale 1ns/10ps
module pin_partner_model (
    input  wire         clk_i,
    input  wire  [19:0] pad_out_i,
    input  wire  [19:0] pad_oe_i,
    input  wire  [19:0] ext_en_i,
    input  wire  [19:0] ext_val_i,
    input  wire  [1:0]  irq_src_i,
    input  wire         pullup_on_i,
    output logic [19:0] pad_in_o,
    output logic        port_e_o
);
logic [19:0] last   = 20'h00000;
logic        last_e = 1'b0;
always @(posedge clk_i) begin
    last <= pad_in_o;
    last_e <= port_e_o;
end
////////////////////////////////////////
// Device drive wins; a floating pad must not look stable
always_comb pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i) | (~pad_oe_i & ~ext_en_i & ~last);
// Any source holds the shared line low until served
always_comb port_e_o = (|irq_src_i) ? 1'b0 : (pullup_on_i ? 1'b1 : ~last_e);
endmodule  // pin_partner_model

// file: port_pin_function_routing_assertions.sv
// Purpose: port checks for the pin routing block
// Assumes: one clock, synchronous active-low reset
// Notes:   general purpose check covers select code zero only
`timescale 1ns/10ps
module pin_routing_checker #(
    parameter PINS = 20
) (
    input wire              clk_i,
    input wire              reset_n_i,
    input wire              port_e_bit0_i,
    input wire              port_e_bit0_o,
    input wire              nonmaskable_irq_req_o,
    input wire              x_mask_clear_i,
    input wire              x_mask_o,
    input wire              pullup_write_i,
    input wire              port_e_pullup_enable_i,
    input wire              port_e_pullup_on_o,
    input wire              expanded_mode_i,
    input wire              onchip_rom_enable_o,
    input wire [3*PINS-1:0] func_sel_i,
    input wire [PINS-1:0]   gpio_dir_i,
    input wire [PINS-1:0]   pad_in_i,
    input wire [PINS-1:0]   pad_oe_o
);
logic [PINS-1:0] gp_mask;
always_comb begin
    for (int p = 0; p < PINS; p++) begin
        gp_mask[p] = (func_sel_i[3*p +: 3] == 3'h0);
    end
end
default clocking cb @(posedge clk_i); endclocking
default disable iff (!reset_n_i);
a_port_e_readable: assert property ($past(reset_n_i) |-> port_e_bit0_o == $past(port_e_bit0_i))
    else $error("port E copy wrong");
a_nmi_needs_cause: assert property (nonmaskable_irq_req_o |-> !x_mask_o && !$past(port_e_bit0_i))
    else $error("request without low pin or while masked");
a_nmi_level: assert property ($past(reset_n_i) && !$past(x_mask_o) && !$past(port_e_bit0_i)
    |-> nonmaskable_irq_req_o) else $error("low pin not requested");
a_mask_track: assert property ($past(reset_n_i) |-> x_mask_o == ($past(x_mask_o) && !$past(x_mask_clear_i)))
    else $error("mask bit wrong");
a_pullup_reset: assert property (disable iff (1'b0) !reset_n_i || !$past(reset_n_i) |-> port_e_pullup_on_o)
    else $error("pull-up off around reset");
a_pullup_write: assert property ($past(reset_n_i) && $past(pullup_write_i)
    |-> port_e_pullup_on_o == $past(port_e_pullup_enable_i)) else $error("pull-up write lost");
a_rom_strap: assert property ($past(reset_n_i) && !$past(reset_n_i, 2)
    |-> onchip_rom_enable_o == ($past(expanded_mode_i) && $past(pad_in_i[2]))) else $error("strap wrong");
a_rom_hold: assert property ($past(reset_n_i) && $past(reset_n_i, 2) |-> $stable(onchip_rom_enable_o))
    else $error("rom enable moved");
a_hiz_reset: assert property (!$past(reset_n_i) || !$past(reset_n_i, 2) |-> pad_oe_o == '0)
    else $error("pad driven around reset");
a_gpio_dir: assert property ($past(reset_n_i) && $past(reset_n_i, 2)
    |-> ((pad_oe_o ^ $past(gpio_dir_i)) & $past(gp_mask)) == '0) else $error("gpio direction lost");
c_nmi: cover property (nonmaskable_irq_req_o);
c_rom: cover property (onchip_rom_enable_o);
c_pullup_off: cover property (!port_e_pullup_on_o);
endmodule  // pin_routing_checker
////////////////////////////////////////
bind port_pin_function_routing pin_routing_checker #(.PINS(PINS)) u_checker (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .port_e_bit0_i(port_e_bit0_i), .port_e_bit0_o(port_e_bit0_o),
    .nonmaskable_irq_req_o(nonmaskable_irq_req_o), .x_mask_clear_i(x_mask_clear_i), .x_mask_o(x_mask_o),
    .pullup_write_i(pullup_write_i), .port_e_pullup_enable_i(port_e_pullup_enable_i),
    .port_e_pullup_on_o(port_e_pullup_on_o), .expanded_mode_i(expanded_mode_i),
    .onchip_rom_enable_o(onchip_rom_enable_o), .func_sel_i(func_sel_i), .gpio_dir_i(gpio_dir_i),
    .pad_in_i(pad_in_i), .pad_oe_o(pad_oe_o)
);

// file: test_port_pin_function_routing.sv
// Purpose: self-checking bench for the pin routing block
// Assumes: partner model closes the pads and the port E line
// Notes:   routing expectations come from the availability table
`timescale 1ns/10ps
module test_port_pin_function_routing;
localparam logic [6:0] AV [20] = '{7'h07, 7'h07, 7'h07, 7'h2D, 7'h2D, 7'h07, 7'h07, 7'h07, 7'h07, 7'h27,
                                    7'h2D, 7'h2D, 7'h25, 7'h40, 7'h40, 7'h13, 7'h13, 7'h2D, 7'h2D, 7'h07};
logic        clk, reset_n, xclr, puw, pue, expd;
logic [59:0] sel;
logic [19:0] gdat, gdir, ext_en, ext_val, snap, e_oe, e_out;
logic [19:0] hout [7];
logic [19:0] hoe [7];
logic [19:0] e_in [7];
logic [1:0]  irq_src;
wire         port_e_pin, port_e_copy, req, xmask, puon, rom;
wire  [19:0] gin, pin, pout, poe;
wire  [19:0] hin [7];
int          failures, total_checks, cycles;
port_pin_function_routing dut (
    .clk_i(clk), .reset_n_i(reset_n), .port_e_bit0_i(port_e_pin), .port_e_bit0_o(port_e_copy),
    .nonmaskable_irq_req_o(req),
    .x_mask_clear_i(xclr), .x_mask_o(xmask), .pullup_write_i(puw), .port_e_pullup_enable_i(pue),
    .port_e_pullup_on_o(puon), .expanded_mode_i(expd), .onchip_rom_enable_o(rom), .func_sel_i(sel),
    .gpio_data_i(gdat), .gpio_dir_i(gdir), .gpio_in_o(gin), .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe),
    .flash_card_host_out_i(hout[0]), .flash_card_host_oe_i(hoe[0]), .flash_card_host_in_o(hin[0]),
    .ata_host_out_i(hout[1]), .ata_host_oe_i(hoe[1]), .ata_host_in_o(hin[1]),
    .nand_media_host_out_i(hout[2]), .nand_media_host_oe_i(hoe[2]), .nand_media_host_in_o(hin[2]),
    .sd_host_out_i(hout[3]), .sd_host_oe_i(hoe[3]), .sd_host_in_o(hin[3]),
    .stick_card_host_out_i(hout[4]), .stick_card_host_oe_i(hoe[4]), .stick_card_host_in_o(hin[4]),
    .capture_timer_out_i(hout[5]), .capture_timer_oe_i(hoe[5]), .capture_timer_in_o(hin[5]),
    .async_serial_port_out_i(hout[6]), .async_serial_port_oe_i(hoe[6]), .async_serial_port_in_o(hin[6]));
pin_partner_model partner (
    .clk_i(clk), .pad_out_i(pout), .pad_oe_i(poe), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .irq_src_i(irq_src), .pullup_on_i(puon), .pad_in_o(pin), .port_e_o(port_e_pin));
initial begin
    clk = 0;
    forever #50 clk = ~clk;
end
always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
        failures++;
        $display("MISMATCH at %0t: run timed out", $time);
        finish_test();
    end
end
////////////////////////////////////////
task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
        failures++;
        $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
endtask
task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
// Unavailable codes fall back to general purpose
function automatic int host_of(int p, logic [59:0] s);
    logic [2:0] c;
    c = s[3*p +: 3];
    if (c != 3'h0 && AV[p][c-1]) return int'(c) - 1;
    return -1;
endfunction
task automatic strap(input logic e, input logic j2);
    reset_n = 0;
    expd = e;
    sel = '0;
    // All pins ask to drive, so only the reset gating keeps them quiet
    gdir = '1;
    ext_en = '1;
    ext_val = {17'h0, j2, 2'h0};
    repeat (8) @(negedge clk);
    chk(poe, 0, "oe in reset");
    chk(puon, 1, "pull-up in reset");
    reset_n = 1;
    @(negedge clk);
    chk(poe, 0, "oe after reset");
    chk(xmask, 1, "mask after reset");
    chk(puon, 1, "pull-up after reset");
    chk(rom, e & j2, "rom strap");
endtask
task automatic route_once();
    int h;
    sel = {28'($urandom()), $urandom()};
    gdat = 20'($urandom());
    gdir = 20'($urandom());
    ext_en = 20'($urandom());
    ext_val = 20'($urandom());
    for (int k = 0; k < 7; k++) begin
        hout[k] = 20'($urandom());
        hoe[k] = 20'($urandom());
        e_in[k] = '0;
    end
    #1 snap = pin;
    for (int p = 0; p < 20; p++) begin
        h = host_of(p, sel);
        e_oe[p] = (h < 0) ? gdir[p] : hoe[h][p];
        e_out[p] = (h < 0) ? gdat[p] : hout[h][p];
        if (h >= 0) e_in[h][p] = snap[p];
    end
    @(negedge clk);
    chk(poe, e_oe, "pad enable");
    chk(pout, e_out, "pad level");
    chk(gin, snap, "gpio input");
    for (int k = 0; k < 7; k++) chk(hin[k], e_in[k], "host input");
endtask
initial begin
    {reset_n, xclr, puw, pue, expd, sel, gdat, gdir, ext_en, ext_val, irq_src} = '0;
    for (int k = 0; k < 7; k++) {hout[k], hoe[k]} = '0;
    void'($urandom(32'h2405bd87));
    for (int i = 0; i < 4; i++) strap(i[1], i[0]);
    $display("test strap done");
    irq_src = 2'b01;
    repeat (3) @(negedge clk);
    chk(req, 0, "request while masked");
    chk(port_e_copy, 0, "port E level");
    xclr = 1;
    @(negedge clk);
    xclr = 0;
    irq_src = 2'b11;
    repeat (2) @(negedge clk);
    chk(req, 1, "request after unmask");
    irq_src = 2'b10;
    repeat (2) @(negedge clk);
    chk(req, 1, "second source holds line");
    irq_src = 2'b00;
    repeat (2) @(negedge clk);
    chk(req, 0, "line released");
    $display("test request done");
    puw = 1;
    @(negedge clk);
    puw = 0;
    chk(puon, 0, "pull-up cleared");
    repeat (3) @(negedge clk);
    {puw, pue} = 2'b11;
    @(negedge clk);
    puw = 0;
    chk(puon, 1, "pull-up set");
    $display("test pull-up done");
    repeat (300) route_once();
    $display("test routing done");
    // Mid-run reset with pull-up off, mask clear and pads driven
    {puw, pue} = 2'b10;
    @(negedge clk);
    puw = 0;
    strap(1, 0);
    $display("test mid-run reset done");
    finish_test();
end
endmodule  // test_port_pin_function_routing
